// [include/rsm_pkg.sv]
// Constants shared by the reset and supply integrity block.
// Assumes a single 250 MHz clock and synchronous register port.
package rsm_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLOCK_MHZ          = 250;
    localparam int unsigned MIN_OUT_WIDTH_NS   = 1000;
    localparam int unsigned MIN_OUT_CYCLES     = (MIN_OUT_WIDTH_NS * CLOCK_MHZ + 999) / 1000;
    localparam int unsigned DELAY_SHORT        = 256;
    localparam int unsigned DELAY_LONG         = 4096;
    localparam int unsigned FETCH_CYCLES       = 2;
    localparam logic [12:0] DELAY_SHORT_W      = 13'h0100;
    localparam logic [12:0] DELAY_LONG_W       = 13'h1000;
    localparam logic [12:0] MIN_OUT_W          = 13'h00FA;
    localparam logic [1:0]  FETCH_W            = 2'h2;
    // ****************************************************************
    // Vector and registers
    // ****************************************************************
    localparam logic [15:0] VECTOR_LO_ADDR     = 16'hFFFE;
    localparam logic [15:0] VECTOR_HI_ADDR     = 16'hFFFF;
    localparam logic [7:0]  INTEGRITY_ADDR     = 8'h00;
    localparam int unsigned SRC_SEL_BIT        = 7;
    localparam int unsigned IRQ_EN_BIT         = 6;
    localparam int unsigned STATUS_BIT         = 5;
    localparam logic [7:0]  INTEGRITY_RESET    = 8'h00;
    // ****************************************************************
    // Options
    // ****************************************************************
    localparam logic [1:0]  OSC_EXTERNAL       = 2'h0;
    localparam logic [1:0]  OSC_RESONATOR      = 2'h1;
    localparam logic [1:0]  OSC_INTERNAL_RC    = 2'h2;
    typedef enum logic [1:0] {
        RSM_ACTIVE = 2'b00,
        RSM_DELAY  = 2'b01,
        RSM_FETCH  = 2'b10,
        RSM_RUN    = 2'b11
    } rsm_phase_t;
endpackage

// [testbench/rsm_board.sv]
// Board model: open-drain reset line with a pull-up and an external pull-low source.
// Assumes the device enable is high while it pulls the line low.
`timescale 1ns/1ns
`default_nettype none
module rsm_board (
    input  wire logic pin_oe,
    input  wire logic ext_hold_low,
    output logic      pin_level
);
    // The pull-up wins unless a party pulls low; the board can hold it low.
    assign pin_level = ~(pin_oe | ext_hold_low);
endmodule // rsm_board
`default_nettype wire

// [testbench/rsm_top_tb.sv]
// Self-checking testbench for the reset sequencer and supply integrity block.
// Assumes the board model on the reset line and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module rsm_top_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        pin_in, pin_oe, pin_out, irq, cpu_reset, vfetch, res_run, dbl_en, lsa;
    logic        hold = 1'b0, wdog = 1'b0, low = 1'b0, aux_s = 1'b0, aux_e = 1'b0;
    logic        long_dly = 1'b0, we = 1'b0, re = 1'b0, ack = 1'b0, lsd_en = 1'b1;
    logic [1:0]  osc = rsm_pkg::OSC_INTERNAL_RC;
    logic [1:0]  csrc, thr;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [15:0] faddr;
    int          errors = 0;
    int          checks = 0;
    always #2 clock = ~clock;
    rsm_board board (.pin_oe(pin_oe), .ext_hold_low(hold), .pin_level(pin_in));
    rsm_top uut (.clock(clock), .rst(rst), .reset_pin_in(pin_in), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .watchdog_underflow(wdog), .low_supply_cmp(low), .aux_cmp_supply(aux_s),
        .aux_cmp_ext_pin(aux_e), .opt_low_supply_en(lsd_en), .opt_threshold(2'h1), .opt_long_delay(long_dly),
        .opt_osc_source(osc), .opt_doubler(1'b1), .reg_addr(addr), .reg_wdata(wdata), .reg_write(we),
        .reg_read(re), .reg_rdata(rdata), .irq_ack(ack), .irq(irq), .cpu_reset(cpu_reset),
        .vector_fetch(vfetch), .fetch_addr(faddr), .resonator_run(res_run), .clock_source(csrc),
        .doubler_en(dbl_en), .detector_threshold(thr), .low_supply_active(lsa));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clock);
        we <= 1'b0;
        tick(5);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        re <= 1'b1;
        @(posedge clock);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic pulse_ack();
        @(posedge clock);
        ack <= 1'b1;
        @(posedge clock);
        ack <= 1'b0;
        tick(2);
        check(16'(irq), 16'h0);
    endtask
    task automatic run_seq(input int lo);
        int n;
        n = 0;
        while (pin_oe !== 1'b1 && n < 8)
        begin
            tick(1);
            n++;
        end
        while (pin_oe === 1'b1 && n < 20000)
        begin
            check(16'(cpu_reset), 16'h1);
            tick(1);
            n++;
        end
        check(16'(n >= lo && n <= lo + 8), 16'h1);
        check(16'(pin_out), 16'h0);
        check(faddr, rsm_pkg::VECTOR_LO_ADDR);
        check(16'(vfetch), 16'h1);
        tick(1);
        check(faddr, rsm_pkg::VECTOR_HI_ADDR);
        check(16'({vfetch, cpu_reset}), 16'h3);
        tick(1);
        check(16'({vfetch, cpu_reset}), 16'h0);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_power_up();
        rst <= 1'b0;
        run_seq(rsm_pkg::DELAY_SHORT);
        check(16'({csrc, dbl_en, thr, lsa}), 16'h23);
        $display("power up sequence finished");
    endtask
    task automatic t_causes();
        @(posedge clock);
        wdog <= 1'b1;
        @(posedge clock);
        wdog <= 1'b0;
        run_seq(rsm_pkg::MIN_OUT_CYCLES + rsm_pkg::DELAY_SHORT);
        @(posedge clock);
        hold <= 1'b1;
        tick(3);
        hold <= 1'b0;
        run_seq(rsm_pkg::MIN_OUT_CYCLES + rsm_pkg::DELAY_SHORT - 4);
        low <= 1'b1;
        repeat (10)
        begin
            tick(100);
            check(16'({pin_oe, cpu_reset}), 16'h3);
        end
        low <= 1'b0;
        run_seq(rsm_pkg::DELAY_SHORT);
        $display("watchdog, pin and supply causes finished");
    endtask
    task automatic t_registers();
        wr(8'h00, 8'hFF);
        rd(8'h00);
        check(16'(d), 16'h00C0);
        aux_e <= 1'b1;
        tick(6);
        rd(8'h00);
        check(16'(d), 16'h00E0);
        check(16'(irq), 16'h1);
        pulse_ack();
        wr(8'h00, 8'h00);
        rd(8'h00);
        check(16'(d), 16'h0000);
        rd(8'h01);
        check(16'(d), 16'h0000);
        $display("register access finished");
    endtask
    task automatic t_irq();
        aux_s <= 1'b1;
        tick(6);
        check(16'(irq), 16'h0);
        wr(8'h00, 8'h40);
        check(16'(irq), 16'h1);
        pulse_ack();
        aux_s <= 1'b0;
        tick(6);
        check(16'(irq), 16'h1);
        pulse_ack();
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h40);
        check(16'(irq), 16'h0);
        lsd_en <= 1'b0;
        aux_s <= 1'b1;
        tick(6);
        rd(8'h00);
        check(16'(d), 16'h0040);
        check(16'({lsa, irq}), 16'h0);
        lsd_en <= 1'b1;
        aux_s <= 1'b0;
        tick(6);
        $display("interrupt sequences finished");
    endtask
    task automatic t_long_delay();
        rst <= 1'b1;
        long_dly <= 1'b1;
        osc <= rsm_pkg::OSC_RESONATOR;
        tick(4);
        check(16'({pin_oe, cpu_reset}), 16'h3);
        rst <= 1'b0;
        tick(2);
        check(16'({res_run, dbl_en, cpu_reset}), 16'h7);
        run_seq(rsm_pkg::DELAY_LONG - 2);
        $display("long delay sequence finished");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        tick(16);
        t_power_up();
        t_causes();
        t_registers();
        t_irq();
        t_long_delay();
        summarize();
    end
    initial
    begin
        #(4 * 40000);
        errors++;
        summarize();
    end
endmodule // rsm_top_tb
`default_nettype wire

// [verilog/rsm_top.sv]
// Reset sequencer, supply detector status and clock option logic.
// Assumes synchronous register port and option inputs stable after reset.
// Functional notes
// - Pin, low supply and watchdog causes each pull reset pin low through delay.
// - Start address is fetched from the two vector bytes at top of memory.
// - Sequence goes active, then 256 or 4096 cycle wait, then vector fetch.
// - Vector fetch phase lasts exactly two clock cycles.
// - A selected resonator oscillator keeps running during reset except while rst is held.
// - External low on reset pin enters reset only through a clocked two-stage synchronizer.
// - Recognised external pulse is stretched to the minimum output width.
// - Watchdog underflow pulls reset pin low for at least minimum width.
// - While supply is low the device stays in reset with pin low.
// - Low supply detector exists only by option; threshold low, medium, high.
// - Clock source chosen by option: external, resonator or internal RC.
// - Clock doubler multiplies by two and is never used with internal RC.
// - Auxiliary detector result is a live read-only status bit.
// - Auxiliary detector works only when the low supply detector is enabled.
// - Source select zero monitors main supply instead of external pin.
// - With interrupt enabled, each status change raises an interrupt.
// - A crossing during the reset delay raises no interrupt.
// - Enabling while status is set raises one interrupt, crossing another.
// - Enabling after the crossing raises no interrupt at enabling.
// - Bit 7 source select, bit 6 interrupt enable, bit 5 status.
// - Status reads one under lower threshold, zero over upper threshold.
// - Pending interrupt clears when its service routine is entered.
`timescale 1ns/1ns
`default_nettype none
module rsm_top (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    input  wire logic        watchdog_underflow,
    input  wire logic        low_supply_cmp,
    input  wire logic        aux_cmp_supply,
    input  wire logic        aux_cmp_ext_pin,
    input  wire logic        opt_low_supply_en,
    input  wire logic [1:0]  opt_threshold,
    input  wire logic        opt_long_delay,
    input  wire logic [1:0]  opt_osc_source,
    input  wire logic        opt_doubler,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [7:0]       reg_rdata,
    input  wire logic        irq_ack,
    output logic             irq,
    output logic             cpu_reset,
    output logic             vector_fetch,
    output logic [15:0]      fetch_addr,
    output logic             resonator_run,
    output logic [1:0]       clock_source,
    output logic             doubler_en,
    output logic [1:0]       detector_threshold,
    output logic             low_supply_active
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rsm_pkg::rsm_phase_t phase;
        logic [12:0]         count;
        logic [12:0]         stretch;
        logic [1:0]          pin_sync;
        logic [1:0]          sup_sync;
        logic [1:0]          cmp_sync;
        logic                status;
        logic                src_sel;
        logic                irq_en;
        logic                pending;
        logic [7:0]          rdata;
        logic                pin_out;
        logic                pin_oe;
        logic                cpu_reset;
        logic                fetch;
        logic [15:0]         faddr;
        logic                res_run;
        logic [1:0]          clk_src;
        logic                dbl;
        logic [1:0]          thr;
        logic                lsd;
    } rsm_state_t;

    rsm_state_t st;
    rsm_state_t next_st;
    logic       cause;
    logic       aux_live;
    logic       cmp_in;

    assign cmp_in = st.src_sel ? aux_cmp_ext_pin : aux_cmp_supply;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        next_st.pin_sync = {st.pin_sync[0], ~reset_pin_in & ~st.pin_oe};
        next_st.sup_sync = {st.sup_sync[0], low_supply_cmp & opt_low_supply_en};
        next_st.cmp_sync = {st.cmp_sync[0], cmp_in & opt_low_supply_en};
        aux_live = st.cmp_sync[1];
        cause = st.pin_sync[1] | st.sup_sync[1] | (st.stretch != 13'h0000);
        if (watchdog_underflow || (st.pin_sync[1] && st.phase != rsm_pkg::RSM_ACTIVE))
        begin
            next_st.stretch = rsm_pkg::MIN_OUT_W;
        end
        else if (st.stretch != 13'h0000)
        begin
            next_st.stretch = st.stretch - 13'h0001;
        end
        case (st.phase)
            rsm_pkg::RSM_ACTIVE:
            begin
                next_st.count = 13'h0000;
                if (!cause)
                begin
                    next_st.phase = rsm_pkg::RSM_DELAY;
                end
            end
            rsm_pkg::RSM_DELAY:
            begin
                next_st.count = st.count + 13'h0001;
                if (st.count == (opt_long_delay ? rsm_pkg::DELAY_LONG_W : rsm_pkg::DELAY_SHORT_W) - 13'h0001)
                begin
                    next_st.phase = rsm_pkg::RSM_FETCH;
                    next_st.count = 13'h0000;
                end
            end
            rsm_pkg::RSM_FETCH:
            begin
                next_st.count = st.count + 13'h0001;
                if (st.count[1:0] == rsm_pkg::FETCH_W - 2'h1)
                begin
                    next_st.phase = rsm_pkg::RSM_RUN;
                end
            end
            rsm_pkg::RSM_RUN:
            begin
                next_st.count = 13'h0000;
            end
            default:
            begin
                next_st.phase = rsm_pkg::RSM_ACTIVE;
            end
        endcase
        if (cause || watchdog_underflow)
        begin
            next_st.phase = rsm_pkg::RSM_ACTIVE;
        end
        next_st.pin_out = 1'b0;
        next_st.pin_oe = (next_st.phase == rsm_pkg::RSM_ACTIVE) || (next_st.phase == rsm_pkg::RSM_DELAY);
        next_st.cpu_reset = next_st.phase != rsm_pkg::RSM_RUN;
        next_st.fetch = next_st.phase == rsm_pkg::RSM_FETCH;
        next_st.faddr = (next_st.phase == rsm_pkg::RSM_FETCH && next_st.count[0]) ?
                        rsm_pkg::VECTOR_HI_ADDR : rsm_pkg::VECTOR_LO_ADDR;
        next_st.res_run = opt_osc_source == rsm_pkg::OSC_RESONATOR;
        next_st.clk_src = opt_osc_source;
        next_st.dbl = opt_doubler && (opt_osc_source != rsm_pkg::OSC_INTERNAL_RC);
        next_st.thr = opt_threshold;
        next_st.lsd = opt_low_supply_en;
        next_st.status = aux_live;
        if (st.phase == rsm_pkg::RSM_RUN && st.irq_en && (aux_live != st.status))
        begin
            next_st.pending = 1'b1;
        end
        else if (irq_ack)
        begin
            next_st.pending = 1'b0;
        end
        if (reg_write && reg_addr == rsm_pkg::INTEGRITY_ADDR)
        begin
            next_st.src_sel = reg_wdata[rsm_pkg::SRC_SEL_BIT];
            next_st.irq_en = reg_wdata[rsm_pkg::IRQ_EN_BIT];
            if (reg_wdata[rsm_pkg::IRQ_EN_BIT] && !st.irq_en && aux_live)
            begin
                next_st.pending = 1'b1;
            end
        end
        next_st.rdata = 8'h00;
        if (reg_read && reg_addr == rsm_pkg::INTEGRITY_ADDR)
        begin
            next_st.rdata[rsm_pkg::SRC_SEL_BIT] = st.src_sel;
            next_st.rdata[rsm_pkg::IRQ_EN_BIT] = st.irq_en;
            next_st.rdata[rsm_pkg::STATUS_BIT] = aux_live;
        end
        if (st.phase != rsm_pkg::RSM_RUN)
        begin
            next_st.src_sel = 1'b0;
            next_st.irq_en = 1'b0;
            next_st.pending = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st <= '{phase: rsm_pkg::RSM_ACTIVE, pin_oe: 1'b1, cpu_reset: 1'b1, faddr: rsm_pkg::VECTOR_LO_ADDR,
                    default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reset_pin_out = st.pin_out;
    assign reset_pin_oe = st.pin_oe;
    assign reg_rdata = st.rdata;
    assign irq = st.pending;
    assign cpu_reset = st.cpu_reset;
    assign vector_fetch = st.fetch;
    assign fetch_addr = st.faddr;
    assign resonator_run = st.res_run;
    assign clock_source = st.clk_src;
    assign doubler_en = st.dbl;
    assign detector_threshold = st.thr;
    assign low_supply_active = st.lsd;

    // ****************************************************************
    // Checks
    // ****************************************************************
    pin_in_delay_a: assert property (@(posedge clock) disable iff (rst)
        st.phase == rsm_pkg::RSM_DELAY |-> st.pin_oe && !st.pin_out) else $error("pin released in delay");
    fetch_two_a: assert property (@(posedge clock) disable iff (rst)
        $rose(st.fetch) |-> st.fetch ##1 st.fetch ##1 !st.fetch) else $error("fetch not two cycles");
    fetch_addr_a: assert property (@(posedge clock) disable iff (rst)
        $rose(st.fetch) |-> st.faddr == 16'hFFFE ##1 st.faddr == 16'hFFFF) else $error("bad vector");
    wdog_hold_a: assert property (@(posedge clock) disable iff (rst)
        watchdog_underflow |=> st.pin_oe [*8]) else $error("watchdog pulse short");
    low_supply_a: assert property (@(posedge clock) disable iff (rst)
        st.sup_sync[1] |=> st.cpu_reset && st.pin_oe) else $error("low supply not held");
    delay_len_a: assert property (@(posedge clock) disable iff (rst)
        $rose(st.phase == rsm_pkg::RSM_DELAY) && !opt_long_delay |-> !st.fetch [*8]) else $error("delay short");
    no_dbl_rc_a: assert property (@(posedge clock) disable iff (rst)
        st.clk_src == rsm_pkg::OSC_INTERNAL_RC |-> !st.dbl) else $error("doubler with rc");
    irq_reset_a: assert property (@(posedge clock) disable iff (rst)
        st.phase != rsm_pkg::RSM_RUN |=> !st.pending) else $error("irq during reset");
    status_off_a: assert property (@(posedge clock) disable iff (rst)
        !opt_low_supply_en [*4] |-> !st.status) else $error("aux active without option");

    // ****************************************************************
    // Sequence and register checks
    // ****************************************************************
    pin_out_low_a: assert property (@(posedge clock) disable iff (rst)
        !st.pin_out)
        else $error("reset pin driven high");

    active_oe_a: assert property (@(posedge clock) disable iff (rst)
        st.phase == rsm_pkg::RSM_ACTIVE |-> st.pin_oe)
        else $error("pin released in active phase");

    run_release_a: assert property (@(posedge clock) disable iff (rst)
        st.phase == rsm_pkg::RSM_RUN |-> !st.pin_oe && !st.cpu_reset)
        else $error("reset held in run");

    fetch_phase_a: assert property (@(posedge clock) disable iff (rst)
        st.fetch == (st.phase == rsm_pkg::RSM_FETCH))
        else $error("fetch flag off phase");

    fetch_entry_a: assert property (@(posedge clock) disable iff (rst)
        st.phase == rsm_pkg::RSM_FETCH |-> $past(st.phase) inside {rsm_pkg::RSM_DELAY, rsm_pkg::RSM_FETCH})
        else $error("fetch without delay");

    run_entry_a: assert property (@(posedge clock) disable iff (rst)
        $rose(st.phase == rsm_pkg::RSM_RUN) |-> $past(st.phase) == rsm_pkg::RSM_FETCH)
        else $error("run without fetch");

    delay_bound_a: assert property (@(posedge clock) disable iff (rst)
        st.phase == rsm_pkg::RSM_DELAY |-> st.count < rsm_pkg::DELAY_LONG_W)
        else $error("delay count overrun");

    short_bound_a: assert property (@(posedge clock) disable iff (rst)
        st.phase == rsm_pkg::RSM_DELAY && !opt_long_delay |-> st.count < rsm_pkg::DELAY_SHORT_W)
        else $error("short delay overrun");

    delay_start_a: assert property (@(posedge clock) disable iff (rst)
        $rose(st.phase == rsm_pkg::RSM_DELAY) |-> st.count == 13'h0000)
        else $error("delay count not cleared");

    fetch_lo_a: assert property (@(posedge clock) disable iff (rst)
        st.fetch && !st.count[0] |-> st.faddr == rsm_pkg::VECTOR_LO_ADDR)
        else $error("low vector byte wrong");

    fetch_hi_a: assert property (@(posedge clock) disable iff (rst)
        st.fetch && st.count[0] |-> st.faddr == rsm_pkg::VECTOR_HI_ADDR)
        else $error("high vector byte wrong");

    idle_addr_a: assert property (@(posedge clock) disable iff (rst)
        !st.fetch |-> st.faddr == rsm_pkg::VECTOR_LO_ADDR)
        else $error("vector address off idle");

    wdog_stretch_a: assert property (@(posedge clock) disable iff (rst)
        watchdog_underflow |=> st.stretch == rsm_pkg::MIN_OUT_W)
        else $error("watchdog stretch not loaded");

    stretch_hold_a: assert property (@(posedge clock) disable iff (rst)
        st.stretch != 13'h0000 |=> st.phase == rsm_pkg::RSM_ACTIVE)
        else $error("stretch left active phase");

    stretch_max_a: assert property (@(posedge clock) disable iff (rst)
        st.stretch <= rsm_pkg::MIN_OUT_W)
        else $error("stretch above width");

    irq_en_clear_a: assert property (@(posedge clock) disable iff (rst)
        st.phase != rsm_pkg::RSM_RUN |=> !st.irq_en)
        else $error("irq enable kept in reset");

    src_clear_a: assert property (@(posedge clock) disable iff (rst)
        st.phase != rsm_pkg::RSM_RUN |=> !st.src_sel)
        else $error("source select kept in reset");

    status_live_a: assert property (@(posedge clock) disable iff (rst)
        st.status == $past(st.cmp_sync[1]))
        else $error("status not live");

    rdata_idle_a: assert property (@(posedge clock) disable iff (rst)
        !$past(reg_read) |-> st.rdata == 8'h00)
        else $error("read data without read");

    rdata_low_a: assert property (@(posedge clock) disable iff (rst)
        st.rdata[4:0] == 5'h00)
        else $error("unused read bits set");

    rdata_sel_a: assert property (@(posedge clock) disable iff (rst)
        $past(reg_read) && $past(reg_addr) == rsm_pkg::INTEGRITY_ADDR |->
        st.rdata[rsm_pkg::SRC_SEL_BIT] == $past(st.src_sel) && st.rdata[rsm_pkg::IRQ_EN_BIT] == $past(st.irq_en))
        else $error("control bits read wrong");

    rdata_status_a: assert property (@(posedge clock) disable iff (rst)
        $past(reg_read) && $past(reg_addr) == rsm_pkg::INTEGRITY_ADDR |->
        st.rdata[rsm_pkg::STATUS_BIT] == $past(st.cmp_sync[1]))
        else $error("status bit read wrong");

    clock_copy_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> st.clk_src == $past(opt_osc_source))
        else $error("clock source not copied");

    thr_copy_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> st.thr == $past(opt_threshold))
        else $error("threshold not copied");

    osc_run_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> st.res_run == ($past(opt_osc_source) == rsm_pkg::OSC_RESONATOR))
        else $error("resonator run wrong");

    lsd_copy_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> st.lsd == $past(opt_low_supply_en))
        else $error("low supply option not copied");

    dbl_copy_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> st.dbl == ($past(opt_doubler) && $past(opt_osc_source) != rsm_pkg::OSC_INTERNAL_RC))
        else $error("doubler enable wrong");

    pend_hold_a: assert property (@(posedge clock) disable iff (rst)
        st.pending && !irq_ack && st.phase == rsm_pkg::RSM_RUN |=> st.pending)
        else $error("interrupt lost without ack");

    ack_clear_a: assert property (@(posedge clock) disable iff (rst)
        irq_ack && st.status == st.cmp_sync[1] && !reg_write |=> !st.pending)
        else $error("ack did not clear");

    pin_mask_a: assert property (@(posedge clock) disable iff (rst)
        st.pin_oe |=> !st.pin_sync[0])
        else $error("own pull seen as external");

    cpu_hold_a: assert property (@(posedge clock) disable iff (rst)
        st.phase != rsm_pkg::RSM_RUN |-> st.cpu_reset)
        else $error("cpu released early");

    supply_gate_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) && !$past(opt_low_supply_en) |-> !st.sup_sync[0])
        else $error("low supply without option");

    aux_gate_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) && !$past(opt_low_supply_en) |-> !st.cmp_sync[0])
        else $error("aux input without option");

endmodule // rsm_top
`default_nettype wire
